// file: rfs_supervisor.sv
// Rail fault supervisor: fault filters, latches, gate override, standby mux
`timescale 1ns/1ps
`default_nettype none
`include "rfs_consts.svh"

// Behaviour
// - Forced single phase: per-phase overcurrent only checked during soft start.
// - Per-phase limit is spike limit times strap ratio over active phase count.
// - Per-phase overcurrent turns every high-side and low-side gate off.
// - Overvoltage monitored from reset on; once tripped the latch holds.
// - Overvoltage latch drives active low-side gates on, high-side off.
// - Overvoltage must persist the deglitch time before latching.
// - Output below reference by the margin sets the undervoltage latch.
// - Undervoltage latch holds all gates of all phases off.
// - Undervoltage must persist its deglitch time before latching.
// - Low supply enters lockout, shutting PWM and all gates off.
// - Low supply must persist its deglitch time before lockout.
// - Rail select high feeds standby rail from the alternate rail.
// - Select low and alternate rail high enough keeps alternate feed.
// - Select low and alternate rail too low switches standby feed to linear regulator.
// - Linear regulator is enabled as soon as supply is up.
// - Total current over spike limit past the delay latches, all gates off.
module rfs_supervisor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire rfs_pkg::rfs_pins_t pins,
   input wire rfs_pkg::rfs_isense_t isense,
   input wire logic soft_start,
   input wire rfs_pkg::rfs_gate_t pwm_in,
   output rfs_pkg::rfs_gate_t gate_out,
   output logic pwm_shutdown,
   output logic ldo_enable,
   output logic standby_from_alt,
   output logic irq
);
   import rfs_pkg::*;

   localparam int OV_CYC = `RFS_OV_CYC;
   localparam int UV_CYC = `RFS_UV_CYC;
   localparam int LOCK_CYC = `RFS_LOCK_CYC;
   localparam int OCP_CYC = `RFS_OCP_CYC;

   rfs_pins_t pins_s;
   logic ov_ok;
   logic uv_ok;
   logic lock_ok;
   logic ocp_ok;
   logic [2:0] strap_cnt_q;
   logic [`RFS_RATIO_W-1:0] ratio_q;
   logic [`RFS_SPIKE_W-1:0] spike_q;
   logic [`RFS_EV_W-1:0] status_q;
   logic [`RFS_EV_W-1:0] mask_q;
   logic [`RFS_EV_W-1:0] latch_q;
   logic [`RFS_EV_W-1:0] set_ev;
   logic [`RFS_EV_W-1:0] w1c;
   logic [10:0] lim_prod;
   logic [7:0] phase_lim;
   logic single_phase;
   logic pocp_eval;
   logic pocp_cond;
   rfs_mode_t mode;
   logic [1:0] active_ph;
   logic addr_ph;
   logic wr_pend_q;
   logic [7:0] wr_ofs_q;
   logic [31:0] rd_word;

   // ====================================================
   // Pin conditioning
   rfs_sync3 #(
      .WIDTH($bits(rfs_pins_t))
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(pins),
      .dout(pins_s)
   );

   // Deglitch filters, one each for overvoltage, undervoltage, low supply and total overcurrent
   rfs_deglitch #(.COUNT(OV_CYC)) u_ov_dg (
      .hclk(hclk),
      .hresetn(hresetn),
      .cond(pins_s.ov_cmp),
      .qualified(ov_ok)
   );

   rfs_deglitch #(.COUNT(UV_CYC)) u_uv_dg (
      .hclk(hclk),
      .hresetn(hresetn),
      .cond(pins_s.uv_cmp),
      .qualified(uv_ok)
   );

   rfs_deglitch #(.COUNT(LOCK_CYC)) u_lock_dg (
      .hclk(hclk),
      .hresetn(hresetn),
      .cond(pins_s.low_supply),
      .qualified(lock_ok)
   );

   rfs_deglitch #(.COUNT(OCP_CYC)) u_ocp_dg (
      .hclk(hclk),
      .hresetn(hresetn),
      .cond(pins_s.total_oc_cmp),
      .qualified(ocp_ok)
   );

   // ====================================================
   // Strap capture: the ratio is taken once the synchroniser has settled,
   // so reset never samples a pin directly. The filtered pin is valid only
   // after the fourth edge past release, so the capture waits for the fifth;
   // an earlier capture would read the cleared synchroniser and give ratio 0.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_cnt_q <= 3'h0;
         ratio_q <= `RFS_RATIO_RST;
      end else if (strap_cnt_q != `RFS_STRAP_SETTLE) begin
         strap_cnt_q <= strap_cnt_q + 3'h1;
         if (strap_cnt_q == `RFS_STRAP_SETTLE - 3'h1) begin
            ratio_q <= pins_s.strap_ratio;
         end
      end
   end

   // ====================================================
   // Per-phase limit: ratio is in eighths, halved when both phases run
   assign single_phase = pins_s.phase_two_sense_neg;
   assign active_ph = single_phase ? 2'b01 : 2'b11;
   assign lim_prod = spike_q * ratio_q;
   assign phase_lim = single_phase ? lim_prod[10:3] : {1'b0, lim_prod[10:4]};
   assign pocp_eval = !single_phase || soft_start;
   assign pocp_cond = pocp_eval &&
      ((isense.ph0 > phase_lim) || (!single_phase && (isense.ph1 > phase_lim)));

   // ====================================================
   // Fault latches: set by qualified conditions, cleared only by reset
   assign set_ev[`RFS_EV_PHASE_OC] = pocp_cond;
   assign set_ev[`RFS_EV_TOTAL_OC] = ocp_ok;
   assign set_ev[`RFS_EV_OV] = ov_ok;
   assign set_ev[`RFS_EV_UV] = uv_ok;
   assign set_ev[`RFS_EV_LOCK] = lock_ok;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_q <= '0;
      end else begin
         latch_q <= latch_q | set_ev;
      end
   end

   // ====================================================
   // Gate override. Lockout outranks all; an overvoltage clamp outranks the
   // off-faults because letting the output float high is the worse hazard.
   always_comb begin
      if (latch_q[`RFS_EV_LOCK]) begin
         mode = RFS_LOCKED;
      end else if (latch_q[`RFS_EV_OV]) begin
         mode = RFS_CLAMP;
      end else if (latch_q[`RFS_EV_PHASE_OC] || latch_q[`RFS_EV_TOTAL_OC] ||
                   latch_q[`RFS_EV_UV]) begin
         mode = RFS_ALL_OFF;
      end else begin
         mode = RFS_RUN;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_out <= '0;
         pwm_shutdown <= 1'b0;
      end else begin
         pwm_shutdown <= (mode == RFS_LOCKED);
         case (mode)
            RFS_RUN: begin
               gate_out.hs <= pwm_in.hs & active_ph;
               gate_out.ls <= pwm_in.ls & active_ph;
            end
            RFS_CLAMP: begin
               gate_out.hs <= 2'b00;
               gate_out.ls <= active_ph;
            end
            default: begin
               gate_out <= '0;
            end
         endcase
      end
   end

   // ====================================================
   // Standby mux and regulator enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         standby_from_alt <= 1'b1;
         ldo_enable <= 1'b0;
      end else begin
         standby_from_alt <= pins_s.rail_sel || pins_s.alt_above;
         ldo_enable <= 1'b1;
      end
   end

   // ====================================================
   // AHB-Lite slave: zero wait, always OKAY, unmapped reads give zero
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ph = hsel && htrans[1] && hready;

   always_comb begin
      case (haddr[7:0])
         `RFS_OFS_STATUS: rd_word = {27'h0, status_q};
         `RFS_OFS_MASK: rd_word = {27'h0, mask_q};
         `RFS_OFS_CONFIG: rd_word = {24'h0, spike_q};
         `RFS_OFS_STATE: rd_word = {17'h0, ratio_q, 1'b0, ldo_enable,
            single_phase, standby_from_alt, 3'h0, latch_q};
         default: rd_word = 32'h0;
      endcase
      if (haddr[31:8] != 24'h0) begin
         rd_word = 32'h0;
      end
   end

   // Address phase capture; read data registered for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend_q <= addr_ph && hwrite && (haddr[31:8] == 24'h0);
         if (addr_ph) begin
            wr_ofs_q <= haddr[7:0];
         end
         if (addr_ph && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   assign w1c = (wr_pend_q && wr_ofs_q == `RFS_OFS_STATUS) ? hwdata[`RFS_EV_W-1:0] : '0;

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= `RFS_MASK_RST;
         spike_q <= `RFS_SPIKE_RST;
      end else if (wr_pend_q) begin
         if (wr_ofs_q == `RFS_OFS_MASK) begin
            mask_q <= hwdata[`RFS_EV_W-1:0];
         end
         if (wr_ofs_q == `RFS_OFS_CONFIG) begin
            spike_q <= hwdata[`RFS_CFG_SPIKE_LSB +: `RFS_SPIKE_W];
         end
      end
   end

   // Sticky status: new trips only, and a set beats a same-cycle clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~w1c) | (set_ev & ~latch_q);
      end
   end

   assign irq = |(status_q & mask_q);

   // ====================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Reset may lift at the very edge that still clears the flops, so an
   // implication spanning that edge carries hresetn in its antecedent.
   a_pocp_single_gate: assert property (
      single_phase && !soft_start && !latch_q[`RFS_EV_PHASE_OC] |=>
      !latch_q[`RFS_EV_PHASE_OC])
      else $error("per-phase trip evaluated outside soft start");
   a_pocp_limit_two: assert property (
      !single_phase && isense.ph0 > {1'b0, lim_prod[10:4]} |=> latch_q[`RFS_EV_PHASE_OC])
      else $error("per-phase limit not applied for two phases");
   a_pocp_gates_off: assert property (
      latch_q[`RFS_EV_PHASE_OC] && !latch_q[`RFS_EV_OV] |=> gate_out == '0)
      else $error("gates on after per-phase trip");
   a_ov_hold: assert property (
      latch_q[`RFS_EV_OV] |=> latch_q[`RFS_EV_OV])
      else $error("overvoltage latch released");
   a_ov_clamp: assert property (
      latch_q[`RFS_EV_OV] && !latch_q[`RFS_EV_LOCK] |=>
      gate_out.hs == 2'b00 && gate_out.ls == active_ph)
      else $error("overvoltage clamp wrong");
   a_ov_deglitch: assert property (
      $rose(latch_q[`RFS_EV_OV]) |-> $past(pins_s.ov_cmp, OV_CYC))
      else $error("overvoltage latched too early");
   a_uv_latch: assert property (
      $rose(latch_q[`RFS_EV_UV]) |-> $past(pins_s.uv_cmp))
      else $error("undervoltage latched without cause");
   a_uv_gates_off: assert property (
      latch_q[`RFS_EV_UV] && !latch_q[`RFS_EV_OV] |=> gate_out == '0)
      else $error("gates on during undervoltage");
   a_uv_deglitch: assert property (
      $rose(latch_q[`RFS_EV_UV]) |-> $past(pins_s.uv_cmp, UV_CYC))
      else $error("undervoltage latched too early");
   a_lock_off: assert property (
      latch_q[`RFS_EV_LOCK] |=> gate_out == '0 && pwm_shutdown)
      else $error("lockout left gates on");
   a_lock_deglitch: assert property (
      $rose(latch_q[`RFS_EV_LOCK]) |-> $past(pins_s.low_supply, LOCK_CYC))
      else $error("lockout entered too early");
   a_mux_alt_sel: assert property (
      pins_s.rail_sel |=> standby_from_alt)
      else $error("standby not on alternate rail");
   a_mux_switch: assert property (
      hresetn && !pins_s.rail_sel |=> standby_from_alt == $past(pins_s.alt_above))
      else $error("standby source wrong");
   a_ldo_on: assert property (
      hresetn |=> ldo_enable)
      else $error("regulator not enabled");
   a_ocp_latch: assert property (
      $rose(latch_q[`RFS_EV_TOTAL_OC]) |-> $past(pins_s.total_oc_cmp, OCP_CYC))
      else $error("total overcurrent latched too early");
   a_status_set_wins: assert property (
      (set_ev & ~latch_q) != '0 |=> (status_q & $past(set_ev & ~latch_q)) ==
      $past(set_ev & ~latch_q))
      else $error("status event lost");
   a_latch_hold: assert property (
      latch_q != '0 |=> (latch_q & $past(latch_q)) == $past(latch_q))
      else $error("fault latch released");
endmodule
`default_nettype wire

// file: rfs_consts.svh
// Constants for the rail fault supervisor: offsets, fields, resets, timing
`ifndef RFS_CONSTS_SVH
`define RFS_CONSTS_SVH

// ====================================================
// Timing
`define RFS_CLK_PERIOD_PS 4000
`define RFS_OV_DEGLITCH_NS 1000
`define RFS_UV_DEGLITCH_NS 3000
`define RFS_LOCK_DEGLITCH_NS 3000
`define RFS_OCP_DELAY_NS 2000
// Least times round up to whole cycles
`define RFS_NS_TO_CYC(ns) (((ns) * 1000 + `RFS_CLK_PERIOD_PS - 1) / `RFS_CLK_PERIOD_PS)
`define RFS_OV_CYC `RFS_NS_TO_CYC(`RFS_OV_DEGLITCH_NS)
`define RFS_UV_CYC `RFS_NS_TO_CYC(`RFS_UV_DEGLITCH_NS)
`define RFS_LOCK_CYC `RFS_NS_TO_CYC(`RFS_LOCK_DEGLITCH_NS)
`define RFS_OCP_CYC `RFS_NS_TO_CYC(`RFS_OCP_DELAY_NS)
`define RFS_STRAP_SETTLE 3'h5

// ====================================================
// Register byte offsets
`define RFS_OFS_STATUS 8'h00
`define RFS_OFS_MASK 8'h04
`define RFS_OFS_CONFIG 8'h08
`define RFS_OFS_STATE 8'h0C

// ====================================================
// Event bit positions (status and mask share them)
`define RFS_EV_PHASE_OC 0
`define RFS_EV_TOTAL_OC 1
`define RFS_EV_OV 2
`define RFS_EV_UV 3
`define RFS_EV_LOCK 4
`define RFS_EV_W 5

// ====================================================
// Config and state fields, reset values
`define RFS_CFG_SPIKE_LSB 0
`define RFS_SPIKE_W 8
`define RFS_RATIO_W 3
`define RFS_SPIKE_RST 8'hC0
`define RFS_MASK_RST 5'h00
`define RFS_RATIO_RST 3'h4
`define RFS_ST_LATCH_LSB 0
`define RFS_ST_ALT_BIT 8
`define RFS_ST_SINGLE_BIT 9
`define RFS_ST_LDO_BIT 10
`define RFS_ST_RATIO_LSB 12

`endif

// file: rfs_pkg.sv
// Types shared by the rail fault supervisor modules
package rfs_pkg;

   // Comparator and strap pins, all asynchronous to hclk
   typedef struct packed {
      logic [2:0] strap_ratio;
      logic phase_two_sense_neg;
      logic rail_sel;
      logic alt_above;
      logic low_supply;
      logic uv_cmp;
      logic ov_cmp;
      logic total_oc_cmp;
   } rfs_pins_t;

   // Gate drive for two phases
   typedef struct packed {
      logic [1:0] hs;
      logic [1:0] ls;
   } rfs_gate_t;

   // Per-phase current codes from the on-chip converter
   typedef struct packed {
      logic [7:0] ph1;
      logic [7:0] ph0;
   } rfs_isense_t;

   // Gate drive mode
   typedef enum logic [1:0] {
      RFS_RUN = 2'b00,
      RFS_ALL_OFF = 2'b01,
      RFS_CLAMP = 2'b10,
      RFS_LOCKED = 2'b11
   } rfs_mode_t;

endpackage

// file: rfs_sync3.sv
// Three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rfs_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // ====================================================
   // Shift chain; s1 feeds s2 only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Bitwise agreement filter rejects a single-cycle disagreement
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout <= '0;
      end else begin
         dout <= (s2_q & s3_q) | (dout & (s2_q | s3_q));
      end
   end
endmodule
`default_nettype wire

// file: rfs_deglitch.sv
// Deglitch counter: condition must hold COUNT cycles before it qualifies
`timescale 1ns/1ps
`default_nettype none
module rfs_deglitch #(
   parameter int COUNT = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cond,
   output logic qualified
);
   localparam int W = $clog2(COUNT + 1);
   localparam logic [W-1:0] TOP = W'(COUNT);
   logic [W-1:0] cnt_q;

   // ====================================================
   // Restart on any drop, saturate at the top
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
      end else if (!cond) begin
         cnt_q <= '0;
      end else if (cnt_q != TOP) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign qualified = cond && (cnt_q == TOP);

   a_count_restart: assert property (@(posedge hclk) disable iff (!hresetn)
      !cond |=> cnt_q == '0) else $error("deglitch count did not restart");
endmodule
`default_nettype wire

// file: rfs_sense_model.sv
// Analog comparator front end facing the supervisor, fed with millivolt codes
`timescale 1ns/1ps
`default_nettype none
module rfs_sense_model #(
   parameter logic [11:0] REF_MV = 12'h44C
) (
   input wire logic [11:0] output_sense_input_mv,
   input wire logic [11:0] alt_mv,
   input wire logic [11:0] ldo_mv,
   input wire logic vcc_low,
   input wire logic spike_hi,
   output logic ov_cmp,
   output logic uv_cmp,
   output logic low_supply,
   output logic total_oc_cmp,
   output logic alt_above
);
   // ==========================================
   // Comparators
   // Ideal levels with no hysteresis, so edge cases show up at once
   assign ov_cmp = output_sense_input_mv > 12'h73A;
   assign uv_cmp = ({1'b0, output_sense_input_mv} + 13'h01F4) < {1'b0, REF_MV};
   assign alt_above = ({1'b0, alt_mv} + 13'h000A) > {1'b0, ldo_mv};
   assign low_supply = vcc_low;
   assign total_oc_cmp = spike_hi;
endmodule
`default_nettype wire

// file: rail_fault_protection_supervisor_test.sv
// Self-checking bench for the rail fault supervisor
`timescale 1ns/1ps
`default_nettype none
module rail_fault_protection_supervisor_test;
   import rfs_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, soft_start;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, strap;
   rfs_pins_t pins;
   rfs_isense_t isense;
   rfs_gate_t pwm_in, gate_out, g;
   logic pwm_shutdown, ldo_enable, standby_from_alt, irq;
   logic [11:0] output_sense_input_mv, alt_mv, ldo_mv;
   logic vcc_low, spike_hi, rail_sel, single, ov, uv, lsup, toc, aa, rd_phase, out_chk;
   logic [31:0] q_rd[$];
   logic [7:0] q_out[$];
   int bad_count, samples_checked, cyc;
   int sh[4] = '{490, 240, 740, 740};
   int lg[4] = '{530, 280, 780, 780};
   rfs_gate_t fg[4] = '{4'h0, 4'h3, 4'h0, 4'h0};

   // ==========================================
   // Structure
   assign pins = {strap, single, rail_sel, aa, lsup, uv, ov, toc};
   assign hready = hreadyout;
   rfs_sense_model sense (.output_sense_input_mv(output_sense_input_mv), .alt_mv(alt_mv), .ldo_mv(ldo_mv),
      .vcc_low(vcc_low), .spike_hi(spike_hi), .ov_cmp(ov), .uv_cmp(uv),
      .low_supply(lsup), .total_oc_cmp(toc), .alt_above(aa));
   rfs_supervisor dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
      .isense(isense), .soft_start(soft_start), .pwm_in(pwm_in), .gate_out(gate_out),
      .pwm_shutdown(pwm_shutdown), .ldo_enable(ldo_enable),
      .standby_from_alt(standby_from_alt), .irq(irq));

   // ==========================================
   // Clock and hang guard
   initial begin
      hclk = 0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         results();
      end
   end

   // ==========================================
   // Compare tasks and output watcher
   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp_out(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Falling edge: registered outputs have long settled
   always @(negedge hclk) begin
      if (rd_phase) cmp_word(hrdata, q_rd.pop_front());
      if (out_chk) cmp_out({gate_out, irq, pwm_shutdown, standby_from_alt, ldo_enable},
         q_out.pop_front());
   end

   // ==========================================
   // Drivers
   task tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // One single transfer; waits on hready in both phases
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      rd_phase <= !wr;
      do @(posedge hclk); while (hready !== 1'b1);
      rd_phase <= 0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] exp);
      q_rd.push_back(exp);
      ahb(0, a, 32'h0);
   endtask
   task expect_out(input logic [7:0] e);
      q_out.push_back(e);
      @(posedge hclk);
      out_chk <= 1;
      @(posedge hclk);
      out_chk <= 0;
   endtask
   // Held four edges; the gates must stay off while it lasts
   task do_reset(input logic sp);
      @(posedge hclk);
      hresetn <= 0;
      single <= sp;
      output_sense_input_mv <= 12'h44C;
      vcc_low <= 0;
      spike_hi <= 0;
      isense <= '0;
      soft_start <= 0;
      tick(1);
      expect_out(8'h02);
      tick(1);
      hresetn <= 1;
      g = rfs_gate_t'(4'($urandom));
      pwm_in <= g;
      tick(8);
   endtask
   task set_fault(input int k, input logic on);
      case (k)
         0: spike_hi <= on;
         1: output_sense_input_mv <= on ? 12'h76C : 12'h44C;
         2: output_sense_input_mv <= on ? 12'h190 : 12'h44C;
         default: vcc_low <= on;
      endcase
   endtask
   task pulse(input int k, input int n);
      @(posedge hclk);
      set_fault(k, 1);
      tick(n);
      set_fault(k, 0);
   endtask
   task results();
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
      rd_phase = 0; out_chk = 0; strap = 3'h4; single = 0; rail_sel = 1; soft_start = 0;
      isense = '0; pwm_in = '0; output_sense_input_mv = 12'h44C; alt_mv = 12'h4B0; ldo_mv = 12'h307;
      vcc_low = 0; spike_hi = 0; bad_count = 0; samples_checked = 0; cyc = 0;
      void'($urandom(32'hF9CE54FC));
      // Reset values, read-only state and an unmapped word
      do_reset(0);
      rd(32'h4, 32'h0);
      rd(32'h8, 32'hC0);
      rd(32'hC, 32'h4500);
      ahb(1, 32'h100, 32'hFFFFFFFF);
      rd(32'h100, 32'h0);
      // Each deglitched fault: two short bursts are filtered, a long one latches for good
      for (int k = 0; k < 4; k++) begin
         do_reset(0);
         ahb(1, 32'h4, 32'h1F);
         pulse(k, sh[k]);
         tick(4);
         pulse(k, sh[k]);
         tick(8);
         expect_out({g, 4'h3});
         pulse(k, lg[k]);
         tick(8);
         expect_out({fg[k], 1'b1, k == 3, 2'h3});
         rd(32'h0, 32'h1 << (k + 1));
         ahb(1, 32'h0, 32'h1F);
         expect_out({fg[k], 1'b0, k == 3, 2'h3});
         rd(32'hC, 32'h4500 | (32'h1 << (k + 1)));
      end
      // Per-phase limit with two phases: (0x40 * 4) / 16 = 16
      do_reset(0);
      ahb(1, 32'h8, 32'h40);
      isense.ph0 <= 8'h10;
      tick(6);
      expect_out({g, 4'h3});
      isense.ph0 <= 8'h11;
      tick(6);
      expect_out(8'h03);
      rd(32'h0, 32'h1);
      // Forced single phase: limit 32, judged only in soft start
      do_reset(1);
      ahb(1, 32'h8, 32'h40);
      isense.ph0 <= 8'hFF;
      tick(6);
      expect_out({g & 4'h5, 4'h3});
      rd(32'hC, 32'h4700);
      soft_start <= 1;
      isense.ph0 <= 8'h21;
      tick(6);
      expect_out(8'h03);
      // Standby source for every select and rail combination
      do_reset(0);
      for (int m = 0; m < 4; m++) begin
         rail_sel <= m[1];
         alt_mv <= m[0] ? 12'h2FE : 12'h2FC;
         tick(8);
         expect_out({g, 2'h0, m != 0, 1'b1});
      end
      tick(4);
      results();
   end
endmodule
`default_nettype wire
